// ---- rtl/ocf_pkg.sv ----
// package for the over-current fault response sequencer
package ocf_pkg;
  // register command codes
  localparam logic [7:0] OCF_CMD_REACTION  = 8'h47;
  localparam logic [7:0] OCF_CMD_LV_THRESH = 8'h48;
  localparam logic [7:0] OCF_CMD_TIME_UNIT = 8'hd2;
  // response byte fields
  localparam int OCF_MODE_HI  = 7;
  localparam int OCF_MODE_LO  = 6;
  localparam int OCF_RETRY_HI = 5;
  localparam int OCF_RETRY_LO = 3;
  localparam int OCF_DLY_HI   = 2;
  localparam int OCF_DLY_LO   = 0;
  localparam logic [1:0] OCF_MODE_CCLV  = 2'h1;
  localparam logic [1:0] OCF_MODE_DELAY = 2'h2;
  localparam logic [1:0] OCF_MODE_OFF   = 2'h3;
  localparam logic [1:0] OCF_MODE_IGNORE = 2'h0;
  localparam logic [2:0] OCF_RETRY_NONE = 3'h0;
  localparam logic [2:0] OCF_RETRY_INF  = 3'h7;
  // reset values
  localparam logic [7:0]  OCF_REACTION_RST = 8'hc0;
  localparam logic [15:0] OCF_LV_RST       = 16'h0000;
  localparam logic [15:0] OCF_UNIT_RST     = 16'h0001;
  // one time unit is this many clocks per unit-register step
  localparam int OCF_CLK_MHZ      = 40;
  localparam int OCF_UNIT_US      = 1;
  localparam int OCF_TICK_CYC     = OCF_UNIT_US * OCF_CLK_MHZ;
  localparam logic [5:0] OCF_TICK_LAST = 6'(OCF_TICK_CYC - 1);

  // register write port
  typedef struct packed {
    logic        wr;
    logic [7:0]  cmd;
    logic [15:0] data;
  } ocf_wr_t;

  typedef enum logic [2:0] {
    OCF_RUN, OCF_LIMIT, OCF_WAIT, OCF_START, OCF_LATCH
  } ocf_state_t;

  // 2 to the delay field, in time units
  function automatic logic [7:0] ocf_units(input logic [2:0] f);
    return 8'(1) << f;
  endfunction : ocf_units
endpackage : ocf_pkg

// ---- rtl/ocf_timer.sv ----
// delay timer counting units of the configured time unit
module ocf_timer
  import ocf_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // control
  input  wire logic        start,
  input  wire logic        clear,
  input  wire logic [7:0]  units,
  input  wire logic [15:0] unit_len,
  // status
  output logic             done
);
  typedef struct packed {
    logic        run;
    logic        done;
    logic [5:0]  tick;
    logic [15:0] sub;
    logic [7:0]  cnt;
  } ocf_tmr_t;

  ocf_tmr_t st_ff, nxt_st;

  // prescaler gives one enable per unit-register step
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (clear) begin
      nxt_st = '0;
    end else if (start) begin
      nxt_st = '0;
      nxt_st.run = 1'b1;
    end else if (st_ff.run) begin
      nxt_st.tick = st_ff.tick + 6'h01;
      if (st_ff.tick == OCF_TICK_LAST) begin
        nxt_st.tick = '0;
        nxt_st.sub = st_ff.sub + 16'h0001;
        // a zero unit length still spends one step per unit
        if (st_ff.sub + 16'h0001 >= unit_len) begin
          nxt_st.sub = '0;
          nxt_st.cnt = st_ff.cnt + 8'h01;
          if (st_ff.cnt + 8'h01 == units) begin
            nxt_st.run = 1'b0;
            nxt_st.done = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) st_ff <= '0;
    else st_ff <= nxt_st;
  end

  assign done = st_ff.done;
endmodule : ocf_timer

// ---- rtl/ocf_seq.sv ----
// over-current fault response sequencer with its settings registers
module ocf_seq
  import ocf_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // register access
  input  ocf_pkg::ocf_wr_t reg_wr,
  input  wire logic [7:0]  rd_cmd,
  output logic [15:0]      rd_data,
  // power stage status; oc_detect and startup_done are synchronised, vout_low is not
  input  wire logic        oc_detect,
  input  wire logic        vout_low,
  input  wire logic        startup_done,
  // control
  input  wire logic        output_on_cmd,
  input  wire logic        other_fault,
  input  wire logic        clear_fault,
  // power stage control and fault status
  output logic             output_enable,
  output logic             current_limit,
  output logic             oc_fault_status,
  output logic             host_alert
);
  typedef struct packed {
    logic [1:0]  s1;
    logic [1:0]  s2;
    logic [7:0]  reaction;
    logic [15:0] lv_thresh;
    logic [15:0] unit_len;
    ocf_state_t  state;
    logic [2:0]  tries;
    logic        on_q;
    logic        en;
    logic        lim;
    logic        flag;
    logic [15:0] rdata;
  } ocf_st_t;

  ocf_st_t st_ff, nxt_st;
  logic t_start, t_clear, t_done;
  logic oc_s, lv_s, up_s, off_edge;
  logic [1:0] mode;
  logic [2:0] retry;

  assign oc_s  = st_ff.s2[0];
  assign up_s  = st_ff.s2[1];
  assign lv_s  = vout_low;
  assign mode  = st_ff.reaction[OCF_MODE_HI:OCF_MODE_LO];
  assign retry = st_ff.reaction[OCF_RETRY_HI:OCF_RETRY_LO];
  assign off_edge = st_ff.on_q && !output_on_cmd;

  // retry budget left after a failure
  function automatic logic can_retry(input logic [2:0] r,
                                     input logic [2:0] n);
    return (r == OCF_RETRY_INF) ||
           ((r != OCF_RETRY_NONE) && (n < r));
  endfunction : can_retry

  ocf_timer u_timer (
    .clk      (clk),
    .rst_b    (rst_b),
    .start    (t_start),
    .clear    (t_clear),
    .units    (ocf_units(st_ff.reaction[OCF_DLY_HI:OCF_DLY_LO])),
    .unit_len (st_ff.unit_len),
    .done     (t_done)
  );

  // sequencer, registers and synchronisers
  always_comb begin
    nxt_st = st_ff;
    t_start = 1'b0;
    t_clear = 1'b0;
    // first stage read only by second stage
    nxt_st.s1 = {startup_done, oc_detect};
    nxt_st.s2 = st_ff.s1;
    nxt_st.on_q = output_on_cmd;
    if (reg_wr.wr) begin
      if (reg_wr.cmd == OCF_CMD_REACTION) begin
        nxt_st.reaction = reg_wr.data[7:0];
      end else if (reg_wr.cmd == OCF_CMD_LV_THRESH) begin
        nxt_st.lv_thresh = reg_wr.data;
      end else if (reg_wr.cmd == OCF_CMD_TIME_UNIT) begin
        nxt_st.unit_len = reg_wr.data;
      end
    end
    // read mux, unmapped reads zero
    if (rd_cmd == OCF_CMD_REACTION) begin
      nxt_st.rdata = {8'h00, st_ff.reaction};
    end else if (rd_cmd == OCF_CMD_LV_THRESH) begin
      nxt_st.rdata = st_ff.lv_thresh;
    end else if (rd_cmd == OCF_CMD_TIME_UNIT) begin
      nxt_st.rdata = st_ff.unit_len;
    end else begin
      nxt_st.rdata = 16'h0000;
    end
    case (st_ff.state)
      OCF_RUN: begin
        nxt_st.en = output_on_cmd;
        nxt_st.lim = 1'b0;
        if (oc_s && output_on_cmd && mode != OCF_MODE_IGNORE) begin
          nxt_st.flag = 1'b1;
          // fresh budget per fault, else a limit path inherits old tries
          nxt_st.tries = '0;
          if (mode == OCF_MODE_OFF) begin
            nxt_st.en = 1'b0;
            nxt_st.state = OCF_LATCH;
            if (can_retry(retry, 3'h0)) begin
              nxt_st.state = OCF_WAIT;
              t_start = 1'b1;
            end
          end else begin
            nxt_st.lim = 1'b1;
            nxt_st.state = OCF_LIMIT;
            t_start = (mode == OCF_MODE_DELAY);
          end
        end
      end
      OCF_LIMIT: begin
        // mode 01 runs here until voltage sags or clear, off command or other fault aborts
        if (mode == OCF_MODE_CCLV && lv_s) begin
          nxt_st.en = 1'b0;
          nxt_st.lim = 1'b0;
          nxt_st.state = can_retry(retry, 3'h0) ? OCF_WAIT : OCF_LATCH;
          t_start = can_retry(retry, 3'h0);
        end else if (mode == OCF_MODE_DELAY && t_done) begin
          nxt_st.lim = 1'b0;
          if (oc_s) begin
            nxt_st.en = 1'b0;
            nxt_st.state = can_retry(retry, 3'h0) ? OCF_WAIT : OCF_LATCH;
            t_start = can_retry(retry, 3'h0);
          end else begin
            nxt_st.state = OCF_RUN;
          end
        end else if (mode != OCF_MODE_CCLV && !oc_s
                     && mode != OCF_MODE_DELAY) begin
          nxt_st.lim = 1'b0;
          nxt_st.state = OCF_RUN;
        end
      end
      OCF_WAIT: begin
        // delay measured start to start of attempts
        if (t_done) begin
          nxt_st.tries = st_ff.tries + 3'h1;
          nxt_st.en = 1'b1;
          nxt_st.state = OCF_START;
          t_start = 1'b1;
        end
      end
      OCF_START: begin
        if (oc_s) begin
          nxt_st.en = 1'b0;
          nxt_st.flag = 1'b1;
          if (can_retry(retry, st_ff.tries)) begin
            nxt_st.state = OCF_WAIT;
          end else begin
            nxt_st.state = OCF_LATCH;
            t_clear = 1'b1;
          end
        end else if (up_s) begin
          nxt_st.state = OCF_RUN;
          t_clear = 1'b1;
        end
      end
      OCF_LATCH: begin
        nxt_st.en = 1'b0;
      end
      default: nxt_st.state = OCF_RUN;
    endcase
    // clear, off command or other fault aborts the sequence
    if (clear_fault || off_edge || other_fault) begin
      nxt_st.state = OCF_RUN;
      nxt_st.tries = '0;
      nxt_st.en = 1'b0;
      nxt_st.lim = 1'b0;
      t_clear = 1'b1;
      t_start = 1'b0;
    end
    if (clear_fault) nxt_st.flag = 1'b0;
    // set beats clear on the same edge, for new faults and failed restarts
    if (oc_s && ((mode != OCF_MODE_IGNORE && st_ff.state == OCF_RUN
        && output_on_cmd) || st_ff.state == OCF_START)) begin
      nxt_st.flag = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_ff <= '0;
      st_ff.reaction <= OCF_REACTION_RST;
      st_ff.lv_thresh <= OCF_LV_RST;
      st_ff.unit_len <= OCF_UNIT_RST;
      st_ff.state <= OCF_RUN;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data         = st_ff.rdata;
  assign output_enable   = st_ff.en;
  assign current_limit   = st_ff.lim;
  assign oc_fault_status = st_ff.flag;
  assign host_alert      = st_ff.flag;

  // mode 11 disables output the edge after the fault is seen
  a_off_at_once: assert property (@(posedge clk) disable iff (!rst_b)
    (st_ff.state == OCF_RUN && oc_s && output_on_cmd && mode == OCF_MODE_OFF
     && !clear_fault && !other_fault && !off_edge)
    |=> !output_enable)
    else $error("mode 11 fault did not disable output");
  a_latch_off: assert property (@(posedge clk) disable iff (!rst_b)
    (st_ff.state == OCF_LATCH) |-> !output_enable)
    else $error("output enabled while latched off");
  a_tries_bound: assert property (@(posedge clk) disable iff (!rst_b)
    (retry != OCF_RETRY_INF && $stable(st_ff.reaction))
    |-> st_ff.tries <= retry)
    else $error("restart count exceeded retry setting");
  a_fail_latch: assert property (@(posedge clk) disable iff (!rst_b)
    (st_ff.state == OCF_START && oc_s && !can_retry(retry, st_ff.tries)
     && !clear_fault && !other_fault && !off_edge)
    |=> st_ff.state == OCF_LATCH)
    else $error("exhausted retries did not latch off");
  a_wait_start: assert property (@(posedge clk) disable iff (!rst_b)
    (st_ff.state == OCF_WAIT && t_done && !clear_fault && !other_fault
     && !off_edge) |=> output_enable && st_ff.state == OCF_START)
    else $error("restart not begun at end of delay");
  a_limit_on: assert property (@(posedge clk) disable iff (!rst_b)
    (st_ff.state == OCF_LIMIT) |-> current_limit && output_enable)
    else $error("limit state without current limiting");
  a_lv_shut: assert property (@(posedge clk) disable iff (!rst_b)
    (st_ff.state == OCF_LIMIT && mode == OCF_MODE_CCLV && lv_s)
    |=> !output_enable)
    else $error("low voltage did not shut output");
  a_clear_reset: assert property (@(posedge clk) disable iff (!rst_b)
    clear_fault |=> st_ff.tries == 3'h0 && st_ff.state == OCF_RUN)
    else $error("clear did not reset sequence");
  a_flag_set: assert property (@(posedge clk) disable iff (!rst_b)
    (st_ff.state == OCF_RUN && oc_s && output_on_cmd
     && mode != OCF_MODE_IGNORE)
    |=> oc_fault_status ##0 host_alert)
    else $error("fault status not set");
  a_thresh_wr: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_wr.wr && reg_wr.cmd == OCF_CMD_LV_THRESH && rd_cmd == OCF_CMD_LV_THRESH)
    ##1 (rd_cmd == OCF_CMD_LV_THRESH) |=> rd_data == $past(reg_wr.data, 2))
    else $error("threshold readback mismatch");

  c_latch: cover property (@(posedge clk) st_ff.state == OCF_LATCH);
  c_retry: cover property (@(posedge clk)
    st_ff.state == OCF_START ##1 st_ff.state == OCF_WAIT);
  c_limit: cover property (@(posedge clk)
    st_ff.state == OCF_LIMIT ##1 st_ff.state == OCF_RUN);
  c_recover: cover property (@(posedge clk)
    st_ff.state == OCF_START ##1 st_ff.state == OCF_RUN);
endmodule : ocf_seq

// ---- testbench/ocf_host.sv ----
// host side model: register writes and reads over the command port
module ocf_host
  import ocf_pkg::*;
(
  // clock
  input  wire logic        clk,
  // register access
  output ocf_pkg::ocf_wr_t reg_wr,
  output logic [7:0]       rd_cmd,
  input  wire logic [15:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus from time zero
  initial begin
    reg_wr = '0;
    rd_cmd = 8'h00;
  end

  // strobe stands for exactly the taking edge
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= '{wr: 1'b1, cmd: c, data: d};
    @(posedge clk);
    reg_wr <= '0;
  endtask : wr

  // read data is registered, so wait two edges past the select
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    @(posedge clk);
    rd_cmd <= c;
    repeat (2) @(posedge clk);
    #1;
    d = rd_data;
  endtask : rd
endmodule : ocf_host

// ---- testbench/overcurrent_fault_response_tb.sv ----
// self-checking bench for the over-current fault response sequencer
module overcurrent_fault_response_tb
  import ocf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic        w;
    logic [7:0]  cmd;
    logic [15:0] data;
    logic [15:0] exp;
  } ocf_row_t;

  logic        clk;
  logic        rst_b;
  ocf_wr_t     reg_wr;
  logic [7:0]  rd_cmd;
  logic [15:0] rd_data;
  logic        oc_detect;
  logic        vout_low;
  logic        startup_done;
  logic        output_on_cmd;
  logic        other_fault;
  logic        clear_fault;
  logic        output_enable;
  logic        current_limit;
  logic        oc_fault_status;
  logic        host_alert;
  int          n_errors;
  int          tests_run;
  int          n;
  logic [15:0] rv;
  // reset values, write back, unmapped place, unit of two
  ocf_row_t    rows [8] = '{
    '{1'b0, 8'h47, 16'h0000, 16'h00c0},
    '{1'b0, 8'h48, 16'h0000, 16'h0000},
    '{1'b0, 8'hd2, 16'h0000, 16'h0001},
    '{1'b1, 8'h48, 16'ha5c3, 16'ha5c3},
    '{1'b1, 8'h48, 16'h5a3c, 16'h5a3c},
    '{1'b1, 8'h47, 16'h00d5, 16'h00d5},
    '{1'b1, 8'h46, 16'h1234, 16'h0000},
    '{1'b1, 8'hd2, 16'h0002, 16'h0002}};

  ocf_seq u_dut (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr),
    .rd_cmd(rd_cmd), .rd_data(rd_data), .oc_detect(oc_detect),
    .vout_low(vout_low), .startup_done(startup_done),
    .output_on_cmd(output_on_cmd), .other_fault(other_fault),
    .clear_fault(clear_fault), .output_enable(output_enable),
    .current_limit(current_limit), .oc_fault_status(oc_fault_status),
    .host_alert(host_alert));

  ocf_host u_host (.clk(clk), .reg_wr(reg_wr), .rd_cmd(rd_cmd),
    .rd_data(rd_data));

  // 40 mhz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic chkb(input logic g, input logic e);
    chk({15'h0, g}, {15'h0, e});
  endtask : chkb

  // bounded wait, k is cycles spent
  task automatic wait_en(input logic v, input int lim, output int k);
    k = 0;
    while (output_enable !== v && k < lim) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask : wait_en

  // restart attempts seen as enable rising
  task automatic rises(input int cyc, output int k);
    logic p;
    k = 0;
    p = output_enable;
    repeat (cyc) begin
      @(posedge clk);
      #1;
      if (output_enable === 1'b1 && p !== 1'b1) k++;
      p = output_enable;
    end
  endtask : rises

  // clear, program, power up; also shows clear restarts the sequence
  task automatic setup(input logic [7:0] cfg);
    @(posedge clk);
    output_on_cmd <= 1'b0;
    oc_detect     <= 1'b0;
    vout_low      <= 1'b0;
    other_fault   <= 1'b0;
    startup_done  <= 1'b1;
    clear_fault   <= 1'b1;
    @(posedge clk);
    clear_fault <= 1'b0;
    u_host.wr(OCF_CMD_REACTION, {8'h00, cfg});
    output_on_cmd <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chkb(output_enable, 1'b1);
    chkb(oc_fault_status, 1'b0);
  endtask : setup

  // watchdog well beyond the longest expected run
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    final_report();
  end

  initial begin
    {rst_b, oc_detect, vout_low, startup_done} = '0;
    {output_on_cmd, other_fault, clear_fault} = '0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) u_host.wr(rows[i].cmd, rows[i].data);
      u_host.rd(rows[i].cmd, rv);
      chk(rv, rows[i].exp);
    end
    // every delay code, unit register left at two
    for (int f = 0; f < 8; f++) begin
      setup({OCF_MODE_OFF, OCF_RETRY_INF, 3'(f)});
      @(posedge clk);
      oc_detect <= 1'b1;
      wait_en(1'b0, 6, n);
      chkb(n <= 4, 1'b1);
      chkb(oc_fault_status & host_alert, 1'b1);
      @(posedge clk);
      oc_detect <= 1'b0;
      wait_en(1'b1, 12000, n);
      rv = 16'((2 * OCF_TICK_CYC) << f);
      chkb(n + 4 >= rv && n <= rv + 4, 1'b1);
    end
    u_host.wr(OCF_CMD_TIME_UNIT, 16'h0001);
    // persistent fault, start-up never completes
    for (int r = 0; r < 8; r++) begin
      setup({OCF_MODE_OFF, 3'(r), 3'h0});
      @(posedge clk);
      oc_detect    <= 1'b1;
      startup_done <= 1'b0;
      rises(560, n);
      chkb(r < 7 ? n == r : n >= 8, 1'b1);
    end
    @(posedge clk);
    other_fault <= 1'b1;
    rises(200, n);
    chkb(n == 0, 1'b1);
    // fault gone before the delay ends: limiting stops, output stays on
    setup({OCF_MODE_DELAY, OCF_RETRY_NONE, 3'h1});
    @(posedge clk);
    oc_detect <= 1'b1;
    repeat (10) @(posedge clk);
    oc_detect <= 1'b0;
    repeat (90) @(posedge clk);
    #1;
    chkb(current_limit | ~output_enable, 1'b0);
    // limit for the delay, then give up
    setup({OCF_MODE_DELAY, OCF_RETRY_NONE, 3'h1});
    @(posedge clk);
    oc_detect <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chkb(current_limit & output_enable, 1'b1);
    wait_en(1'b0, 200, n);
    chkb(n >= 74 && n <= 84, 1'b1);
    rises(200, n);
    chkb(n == 0, 1'b1);
    // limit without end until the voltage sags
    setup({OCF_MODE_CCLV, OCF_RETRY_NONE, 3'h0});
    @(posedge clk);
    oc_detect <= 1'b1;
    wait_en(1'b0, 300, n);
    chkb(n == 300 && current_limit, 1'b1);
    @(posedge clk);
    vout_low <= 1'b1;
    wait_en(1'b0, 6, n);
    chkb(n <= 4, 1'b1);
    // ignored fault leaves no status
    setup(8'h00);
    @(posedge clk);
    oc_detect <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chkb(oc_fault_status | ~output_enable, 1'b0);
    final_report();
  end
endmodule : overcurrent_fault_response_tb
